// ### include/ipa_defines.svh
// Offsets, field positions, reset values and codes of the interrupt prioritizer
`ifndef IPA_DEFINES_SVH
`define IPA_DEFINES_SVH

// Register offsets (byte addresses, 12-bit register space)
`define IPA_OFS_LEVEL_SUMMARY 12'h718
`define IPA_OFS_ACK_LP        12'h719
// Control registers: offset 0x740 + source, so address bits 11:6 = 0x1D
`define IPA_CTRL_PAGE         6'h1D
// Acknowledge registers: 0x7E0 + 4 * level, level 0 = software acknowledge
`define IPA_ACK_PAGE          6'h3F
// Address bit that selects the global copy of the acknowledge registers
`define IPA_GLOBAL_BIT        11

// Control register field positions
`define IPA_CTL_LVL_MSB       5
`define IPA_CTL_LVL_LSB       3
`define IPA_CTL_PRI_MSB       2
`define IPA_CTL_PRI_LSB       0
// Acknowledged level/priority field position
`define IPA_LP_LVL_LSB        4

// Reset value of every byte register
`define IPA_RST_BYTE          8'h00
// Last source with a fixed level
`define IPA_FIXED_LAST        6'h07
// Priority code reported for a fixed-level source
`define IPA_MID_PRI           4'h8
// Internal rank of the midpoint: between programmable 3 (6) and 4 (8)
`define IPA_MID_RANK          4'h7
// Vector of source n is base + n
`define IPA_VECTOR_BASE       8'h40
// Source that carries the OR of all USB requests
`define IPA_USB_OR_SRC        24
// Sources that have a request wired to them
`define IPA_USED_MASK         64'h7861_8FFF_FFFF_80FE

`endif

// ### include/ipa_pkg.sv
// Types and ranking functions shared by the interrupt prioritizer files
package ipa_pkg;
  `include "ipa_defines.svh"

  // Decoded setting of one source
  typedef struct packed {
    logic       fixed;  // Level fixed by hardware
    logic [2:0] level;  // 0 = disabled, 1..7
    logic [2:0] prio;   // 0 lowest, 7 highest
  } ipa_src_cfg_t;

  // Outcome of one arbitration
  typedef struct packed {
    logic       found;  // Some source qualified
    logic [5:0] idx;    // Winning source number
    logic [2:0] level;  // Its level
    logic [3:0] rank;   // Its rank inside the level
    logic [3:0] acknowledged_priority;    // Priority code as reported
  } ipa_win_t;

  // Acknowledged level/priority byte
  typedef struct packed {
    logic       rsvd;
    logic [2:0] level;
    logic [3:0] acknowledged_priority;
  } ipa_ack_lp_t;

  // Register access from the core
  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } ipa_reg_req_t;

  // Rank inside a level; doubling leaves room for the midpoint
  function automatic logic [3:0] ipa_rank(input ipa_src_cfg_t c);
    ipa_rank = c.fixed ? `IPA_MID_RANK : {c.prio, 1'b0}; // RULE_08 RULE_23
  endfunction

  // Priority code loaded on acknowledge
  function automatic logic [3:0] ipa_pri_code(input ipa_src_cfg_t c);
    ipa_pri_code = c.fixed ? `IPA_MID_PRI : {1'b0, c.prio}; // RULE_05
  endfunction
endpackage

// ### verilog/ipa_arbiter.sv
// Combinational winner search over all sources, optionally inside one level
module ipa_arbiter
  import ipa_pkg::*;
#(
  parameter int N = 63
) (
  input  wire logic                 [N:1] active,
  input  wire ipa_src_cfg_t         [N:1] cfg,
  input  wire logic                 [2:0] level_sel,
  output ipa_win_t                        win
);

  // Linear scan; strict compare keeps the lowest index on a tie,
  // ties only arise from overlapping settings, which are undefined
  always_comb begin
    win = '0;
    for (int i = 1; i <= N; i++) begin
      if (active[i] && cfg[i].level != 3'h0 // RULE_11
          && (level_sel == 3'h0 || cfg[i].level == level_sel) // RULE_15
          && (!win.found
              || {cfg[i].level, ipa_rank(cfg[i])} > {win.level, win.rank})) begin // RULE_16
        win.found = 1'b1;
        win.idx   = 6'(i);
        win.level = cfg[i].level;
        win.rank  = ipa_rank(cfg[i]); // RULE_09 RULE_08 RULE_23
        win.acknowledged_priority   = ipa_pri_code(cfg[i]); // RULE_05
      end
    end
  end

endmodule

// ### verilog/ipa_ctrl_regs.sv
// Per-source level/priority control registers, sources 1..63
module ipa_ctrl_regs
  import ipa_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               wr_en,
  input  wire logic         [5:0] idx,
  input  wire logic         [7:0] wr_data,
  output logic              [7:0] rd_data,
  output ipa_src_cfg_t     [63:1] cfg
);

  // Storage only for the writable sources
  logic [5:0] ctl      [63:8];
  logic [5:0] next_ctl [63:8];

  // Write decode; sources below 8 have no storage so writes fall away
  always_comb begin
    for (int i = 8; i <= 63; i++) begin
      next_ctl[i] = ctl[i];
      if (wr_en && idx == 6'(i)) begin
        next_ctl[i] = wr_data[`IPA_CTL_LVL_MSB:`IPA_CTL_PRI_LSB]; // RULE_07 RULE_06
      end
    end
  end

  // Registers clear to the disabled setting
  always_ff @(posedge clk) begin
    for (int i = 8; i <= 63; i++) begin
      if (sys_rst) begin
        ctl[i] <= 6'h00; // RULE_06 RULE_11
      end else begin
        ctl[i] <= next_ctl[i];
      end
    end
  end

  // Decoded settings; fixed sources sit at the level of their number
  always_comb begin
    for (int i = 1; i <= 7; i++) begin
      cfg[i] = '{fixed: 1'b1, level: 3'(i), prio: 3'h0};
    end
    for (int i = 8; i <= 63; i++) begin
      cfg[i] = '{fixed: 1'b0,
                 level: ctl[i][`IPA_CTL_LVL_MSB:`IPA_CTL_LVL_LSB],
                 prio:  ctl[i][`IPA_CTL_PRI_MSB:`IPA_CTL_PRI_LSB]};
    end
  end

  // Read mux; reserved bits 7:6 always zero, fixed priority reads 000b
  always_comb begin
    if (idx > `IPA_FIXED_LAST) begin
      rd_data = {2'h0, ctl[idx]}; // RULE_06
    end else if (idx != 6'h00) begin
      rd_data = {2'h0, idx[2:0], 3'h0}; // RULE_09
    end else begin
      rd_data = `IPA_RST_BYTE;
    end
  end

endmodule

// ### verilog/ipa_prioritizer.sv
// Interrupt prioritizer: level summary, acknowledge arbitration, register file
`include "ipa_defines.svh"

// Function
// RULE_01: Summary bits 7..1 flag active levels
// RULE_02: Summary refreshed every cycle, bit n level n
// RULE_03: Every acknowledge loads level/priority byte
// RULE_04: Byte: bit7 reserved, level 6:4, priority 3:0
// RULE_05: Priority 0..7, code 8 for fixed sources
// RULE_06: Control byte: level 5:3, priority 2:0
// RULE_07: All readable, only sources 8..63 writable
// RULE_08: Priority 000b lowest, 111b highest
// RULE_09: Fixed sources use midpoint, read 000b
// RULE_10: Software keeps level/priority pairs unique
// RULE_11: All-zero control byte disables the source
// RULE_12: Inputs 1..7 edge flags, unused stay idle
// RULE_13: Source 24 is OR of USB requests
// RULE_14: Register read and hardware acknowledge alike
// RULE_15: Level acknowledge picks best within that level
// RULE_16: Software acknowledge picks best level then priority
// RULE_17: Nothing active: zero vector, byte cleared
// RULE_18: Global acknowledge spans all controllers
// RULE_19: Service routine acknowledges by software near end
// RULE_20: Mask excludes source, pending follows raw
// RULE_21: Force bit activates source despite mask
// RULE_22: Vector is base plus source number
// RULE_23: Midpoint ranks between priorities 3 and 4
module ipa_prioritizer
  import ipa_pkg::*;
#(
  parameter int USB_W = 9
) (
  input  wire logic               clk,
  input  wire ipa_reg_req_t       reg_req,
  output logic              [7:0] reg_rdata,
  output logic                    reg_rvalid,
  input  wire logic               interrupt_acknowledge_req,
  input  wire logic         [2:0] interrupt_acknowledge_level,
  output logic              [7:0] interrupt_acknowledge_vector,
  output logic                    interrupt_acknowledge_done,
  input  wire logic        [63:1] periph_req,
  input  wire logic   [USB_W-1:0] usb_req,
  input  wire logic         [7:1] edge_flag_register,
  input  wire logic        [63:1] source_mask_bits,
  input  wire logic        [63:1] software_force_bits,
  output logic             [63:1] source_pending_bits,
  output logic              [7:0] level_request_summary,
  output ipa_ack_lp_t             acknowledged_level_priority,
  input  wire logic               sys_rst
);

  // Request wiring
  wire logic         [63:0] used_mask = `IPA_USED_MASK; // Sources with a wire
  logic              [63:1] raw_req;         // Request as the peripherals drive it
  logic              [63:1] active;          // Request that may win
  ipa_src_cfg_t      [63:1] cfg;             // Decoded control bytes

  // Register decode
  logic                     ctrl_hit;        // Address in control block
  logic                     ack_hit;         // Address in acknowledge block
  logic               [7:0] ctrl_rd_data;    // Control byte read back

  // Acknowledge engine
  logic                     ack_go;          // An acknowledge happens now
  logic               [2:0] ack_lvl;         // 0 = software, else level
  ipa_win_t                 win;             // Arbitration result
  logic               [7:0] win_vector;      // Vector of the winner or zero

  // Next values of the output flops
  logic               [7:0] next_summary;
  ipa_ack_lp_t              next_lp;
  logic               [7:0] next_rdata;
  logic               [7:0] next_vector;

  // Raw requests: unwired inputs forced idle, edge flags and USB OR spliced in
  always_comb begin
    raw_req = periph_req & used_mask[63:1]; // RULE_12
    raw_req[7:1] = edge_flag_register; // RULE_12
    raw_req[`IPA_USB_OR_SRC] = |usb_req; // RULE_13
  end

  // Mask gates the raw request, force bypasses the mask
  assign active = (raw_req & ~source_mask_bits) | software_force_bits; // RULE_20 RULE_21

  // Control registers
  ipa_ctrl_regs u_ctrl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (reg_req.wr && ctrl_hit),
    .idx     (reg_req.addr[5:0]),
    .wr_data (reg_req.wdata),
    .rd_data (ctrl_rd_data),
    .cfg     (cfg)
  );

  // Address decode; the global copy differs only in the top address bit
  always_comb begin
    ctrl_hit = reg_req.addr[11:6] == `IPA_CTRL_PAGE;
    ack_hit  = reg_req.addr[10:5] == `IPA_ACK_PAGE && reg_req.addr[1:0] == 2'h0; // RULE_18
  end

  // Hardware cycle takes the engine; a register read of the block waits
  // for nothing, so the core must not issue both in one cycle
  always_comb begin
    ack_go  = interrupt_acknowledge_req || (reg_req.rd && ack_hit); // RULE_14
    ack_lvl = interrupt_acknowledge_req ? interrupt_acknowledge_level : reg_req.addr[4:2]; // RULE_14
  end

  // One arbiter serves all acknowledge kinds
  ipa_arbiter #(
    .N (63)
  ) u_arb (
    .active    (active),
    .cfg       (cfg),
    .level_sel (ack_lvl),
    .win       (win)
  );

  // Unique non-zero vector per source
  assign win_vector = win.found ? `IPA_VECTOR_BASE + {2'h0, win.idx} : 8'h00; // RULE_22 RULE_17

  // Level summary: one bit per level that has an active enabled source
  always_comb begin
    next_summary = 8'h00;
    for (int i = 1; i <= 63; i++) begin
      if (active[i] && cfg[i].level != 3'h0) begin
        next_summary[cfg[i].level] = 1'b1; // RULE_01 RULE_02
      end
    end
    next_summary[0] = 1'b0; // RULE_01
  end

  // Acknowledged level/priority: loaded on every acknowledge
  always_comb begin
    next_lp = acknowledged_level_priority;
    if (ack_go) begin
      if (win.found) begin
        next_lp = '{rsvd: 1'b0, level: win.level, acknowledged_priority: win.acknowledged_priority}; // RULE_03 RULE_04 RULE_05
      end else begin
        next_lp = '0; // RULE_17
      end
    end
  end

  // Register read data; unmapped addresses read zero
  always_comb begin
    next_rdata = `IPA_RST_BYTE;
    if (ctrl_hit) begin
      next_rdata = ctrl_rd_data; // RULE_07
    end else if (ack_hit) begin
      // A clashing hardware cycle owns the arbiter
      next_rdata = interrupt_acknowledge_req ? 8'h00 : win_vector; // RULE_16
    end else if (reg_req.addr == `IPA_OFS_LEVEL_SUMMARY) begin
      next_rdata = level_request_summary;
    end else if (reg_req.addr == `IPA_OFS_ACK_LP) begin
      next_rdata = acknowledged_level_priority;
    end
  end

  // Hardware acknowledge vector
  always_comb begin
    next_vector = interrupt_acknowledge_vector;
    if (interrupt_acknowledge_req) begin
      next_vector = win_vector; // RULE_15
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_request_summary       <= `IPA_RST_BYTE;
      acknowledged_level_priority <= '0; // RULE_04
      source_pending_bits         <= '0;
      reg_rdata                   <= `IPA_RST_BYTE;
      reg_rvalid                  <= 1'b0;
      interrupt_acknowledge_vector                 <= `IPA_RST_BYTE;
      interrupt_acknowledge_done                   <= 1'b0;
    end else begin
      level_request_summary       <= next_summary; // RULE_02
      acknowledged_level_priority <= next_lp;
      source_pending_bits         <= raw_req; // RULE_20
      reg_rdata                   <= reg_req.rd ? next_rdata : `IPA_RST_BYTE;
      reg_rvalid                  <= reg_req.rd;
      interrupt_acknowledge_vector                 <= next_vector;
      interrupt_acknowledge_done                   <= interrupt_acknowledge_req;
    end
  end

  // Checks

  // Bit 0 of the summary never set
  summary_bit0_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    level_request_summary[0] == 1'b0)
    else $error("summary bit 0 set");

  // Nothing active means empty summary next cycle
  summary_empty_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    (active == '0) |=> (level_request_summary == 8'h00))
    else $error("summary not empty with no request");

  // Reset clears the acknowledged byte and summary
  reset_clear_a: assert property (@(posedge clk) // RULE_04
    sys_rst |=> (acknowledged_level_priority == 8'h00 && level_request_summary == 8'h00))
    else $error("reset did not clear outputs");

  // Reserved bit of acknowledged byte stays zero
  lp_reserved_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    acknowledged_level_priority.rsvd == 1'b0)
    else $error("acknowledged byte reserved bit set");

  // Programmable winner never reports the midpoint code
  lp_prog_code_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    (ack_go && win.found && win.idx > `IPA_FIXED_LAST)
    |=> acknowledged_level_priority.acknowledged_priority < `IPA_MID_PRI)
    else $error("programmable source reported midpoint");

  // Hardware level acknowledge returns vector and level
  hw_ack_vec_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    (interrupt_acknowledge_req && interrupt_acknowledge_level != 3'h0 && win.found)
    |=> (interrupt_acknowledge_done && interrupt_acknowledge_vector == `IPA_VECTOR_BASE + {2'h0, $past(win.idx)}
         && acknowledged_level_priority.level == $past(interrupt_acknowledge_level)))
    else $error("level acknowledge result wrong");

  // Empty software acknowledge returns zero and clears the byte
  sw_ack_empty_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
    (reg_req.rd && ack_hit && !interrupt_acknowledge_req && !win.found)
    |=> (reg_rvalid && reg_rdata == 8'h00 && acknowledged_level_priority == 8'h00))
    else $error("empty acknowledge not cleared");

  // Control byte reserved bits read zero
  ctrl_reserved_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    (reg_req.rd && ctrl_hit) |=> (reg_rvalid && reg_rdata[7:6] == 2'h0))
    else $error("control byte reserved bits set");

  // Fixed source read back keeps priority field zero
  fixed_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    (reg_req.rd && ctrl_hit && reg_req.addr[5:0] <= `IPA_FIXED_LAST
     && reg_req.addr[5:0] != 6'h00)
    |=> (reg_rvalid && reg_rdata == {2'h0, $past(reg_req.addr[2:0]), 3'h0}))
    else $error("fixed source priority not zero");

  // Hardware acknowledge answered exactly one cycle later
  hw_ack_done_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
    interrupt_acknowledge_req |=> interrupt_acknowledge_done)
    else $error("acknowledge not answered");

  // Pending follows the raw request whatever the mask says
  pending_raw_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_20
    !sys_rst |=> source_pending_bits == $past(raw_req))
    else $error("pending bits do not follow requests");

  // Inputs without a wired source never show a request
  unwired_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    (source_pending_bits & ~used_mask[63:1]) == 63'h0)
    else $error("unwired source pending");

  // Source 24 is the OR of every USB request
  usb_or_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
    !sys_rst |=> source_pending_bits[`IPA_USB_OR_SRC] == $past(|usb_req))
    else $error("USB summary request wrong");

  // Level acknowledge only picks from the asked level
  level_pick_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    (interrupt_acknowledge_req && interrupt_acknowledge_level != 3'h0 && win.found) |-> win.level == interrupt_acknowledge_level)
    else $error("winner outside acknowledged level");

  // Software acknowledge finds a winner whenever some level is requested
  sw_found_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
    (ack_go && ack_lvl == 3'h0) |-> win.found == (next_summary != 8'h00))
    else $error("software acknowledge missed a request");

  // Software acknowledge returns the winner's vector
  sw_ack_vec_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
    (reg_req.rd && ack_hit && !interrupt_acknowledge_req && win.found)
    |=> (reg_rvalid && reg_rdata == `IPA_VECTOR_BASE + {2'h0, $past(win.idx)}))
    else $error("software acknowledge vector wrong");

  // Every acknowledge that finds a source records its level and priority
  lp_load_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    (ack_go && win.found)
    |=> acknowledged_level_priority == {1'b0, $past(win.level), $past(win.acknowledged_priority)})
    else $error("level/priority byte not loaded");

  // Fixed sources sit at their own level and report the midpoint
  fixed_code_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    (ack_go && win.found && win.idx <= `IPA_FIXED_LAST)
    |-> (win.acknowledged_priority == `IPA_MID_PRI && win.level == win.idx[2:0]))
    else $error("fixed source code wrong");

  // A winner never maps to the empty vector
  vec_nonzero_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_22
    win.found |-> win_vector != 8'h00)
    else $error("winner has zero vector");

  // Read data is zero and the strobe low when no read was taken
  rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
    !reg_req.rd |=> (!reg_rvalid && reg_rdata == 8'h00))
    else $error("read answer without a read");

  // Hardware vector holds between acknowledge cycles
  vector_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    !interrupt_acknowledge_req |=> $stable(interrupt_acknowledge_vector))
    else $error("acknowledge vector changed unasked");

  hw_ack_found_c: cover property (@(posedge clk) disable iff (sys_rst)
    interrupt_acknowledge_req && win.found);
  sw_ack_empty_c: cover property (@(posedge clk) disable iff (sys_rst)
    reg_req.rd && ack_hit && !win.found);
  fixed_win_c: cover property (@(posedge clk) disable iff (sys_rst)
    ack_go && win.found && win.acknowledged_priority == `IPA_MID_PRI);
  ctrl_write_c: cover property (@(posedge clk) disable iff (sys_rst)
    reg_req.wr && ctrl_hit ##1 reg_req.rd && ctrl_hit);

endmodule

// ### verification/ipa_core_model.sv
// Core-side model: register accesses and hardware acknowledge cycles
module ipa_core_model
  import ipa_pkg::*;
(
  input  wire logic         clk,
  output ipa_reg_req_t      reg_req,
  output logic              interrupt_acknowledge_req,
  output logic        [2:0] interrupt_acknowledge_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial begin
    reg_req = '0;
    interrupt_acknowledge_req = 1'b0;
    interrupt_acknowledge_level = 3'h0;
  end

  // One write strobe, held across exactly one sampling edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge clk);
    reg_req = '0;
  endtask

  // One read strobe; the answer is picked up by the bench monitor
  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    reg_req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(negedge clk);
    reg_req = '0;
  endtask

  // Hardware acknowledge pulse, never in the same cycle as a read
  task automatic ack(input logic [2:0] l);
    @(negedge clk);
    interrupt_acknowledge_req = 1'b1;
    interrupt_acknowledge_level = l;
    @(negedge clk);
    interrupt_acknowledge_req = 1'b0;
  endtask
endmodule

// ### verification/ipa_prioritizer_test.sv
// Self-checking bench for the interrupt prioritizer
`include "ipa_defines.svh"
module ipa_prioritizer_test
  import ipa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk;        // System clock
  logic               sys_rst;    // Synchronous reset
  ipa_reg_req_t       reg_req;    // Core register access
  logic         [7:0] reg_rdata;  // Read answer
  logic               reg_rvalid; // Read answer strobe
  logic               interrupt_acknowledge_req;   // Hardware acknowledge
  logic         [2:0] interrupt_acknowledge_level; // Level acknowledged
  logic         [7:0] interrupt_acknowledge_vector;
  logic               interrupt_acknowledge_done;
  logic        [63:1] periph_req;
  logic         [8:0] usb_req;
  logic         [7:1] edge_flag_register;
  logic        [63:1] source_mask_bits;
  logic        [63:1] software_force_bits;
  logic        [63:1] source_pending_bits;
  logic         [7:0] level_request_summary;
  ipa_ack_lp_t        acknowledged_level_priority;
  logic         [7:0] rd_q[$];    // Expected read data, oldest first
  logic        [15:0] ak_q[$];    // Expected vector and level/priority
  int                 fail_count;
  int                 total_checks;
  int                 seed;       // Fixed seed keeps runs repeatable
  logic         [2:0] r;          // Random priority of source 40

  // Free-running clock, 8 ns period
  always #4 clk = ~clk;

  ipa_core_model core (.clk(clk), .reg_req(reg_req), .interrupt_acknowledge_req(interrupt_acknowledge_req),
    .interrupt_acknowledge_level(interrupt_acknowledge_level));

  ipa_prioritizer dut (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .interrupt_acknowledge_req(interrupt_acknowledge_req), .interrupt_acknowledge_level(interrupt_acknowledge_level),
    .interrupt_acknowledge_vector(interrupt_acknowledge_vector), .interrupt_acknowledge_done(interrupt_acknowledge_done), .periph_req(periph_req),
    .usb_req(usb_req), .edge_flag_register(edge_flag_register),
    .source_mask_bits(source_mask_bits), .software_force_bits(software_force_bits),
    .source_pending_bits(source_pending_bits),
    .level_request_summary(level_request_summary),
    .acknowledged_level_priority(acknowledged_level_priority), .sys_rst(sys_rst));

  // Vector expected for a source number
  function automatic logic [7:0] vec(input int n);
    vec = `IPA_VECTOR_BASE + 8'(n);
  endfunction

  // Compare of one byte result
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compare of one acknowledge result
  task automatic check_ack(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t acknowledge got %h exp %h", $time, got, exp);
    end
  endtask

  // Read with its expected data noted first
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    core.rd(a);
  endtask

  // Hardware acknowledge with its expected outcome
  task automatic ack(input logic [2:0] l, input logic [7:0] v, input logic [7:0] lp);
    ak_q.push_back({v, lp});
    core.ack(l);
  endtask

  // Software acknowledge, then read back the recorded level/priority
  task automatic sw(input logic [7:0] v, input logic [7:0] lp);
    rd(12'h7E0, v);
    rd(12'h719, lp);
  endtask

  // Let registered request paths catch up
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  // Verdict; leftover notes mean an answer never came
  task automatic finish_test;
    if (rd_q.size() != 0 || ak_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Monitor: each answer takes the oldest note off its queue
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (rd_q.size() == 0) check8(reg_rdata, 8'hEE, "unexpected read");
      else check8(reg_rdata, rd_q.pop_front(), "read data");
    end
    if (interrupt_acknowledge_done === 1'b1) begin
      if (ak_q.size() == 0) check_ack(16'hEEEE, 16'h0000);
      else check_ack({interrupt_acknowledge_vector, acknowledged_level_priority}, ak_q.pop_front());
    end
  end

  // Watchdog: run should end well inside 25000 cycles
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    periph_req = '0;
    usb_req = '0;
    edge_flag_register = '0;
    source_mask_bits = '0;
    software_force_bits = '0;
    fail_count = 0;
    total_checks = 0;
    seed = 67;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    rd(12'h718, 8'h00);
    rd(12'h719, 8'h00);
    rd(12'h760, 8'h00);
    rd(12'h741, 8'h08);
    r = 3'($random(seed));
    core.wr(12'h743, 8'h3F);
    core.wr(12'h74F, 8'hDC);
    core.wr(12'h750, 8'h1B);
    core.wr(12'h768, {5'h05, r});
    core.wr(12'h758, 8'h38);
    rd(12'h743, 8'h18);
    rd(12'h74F, 8'h1C);
    edge_flag_register[3] = 1'b1;
    periph_req[16:15] = 2'b11;
    periph_req[20] = 1'b1;
    periph_req[14:8] = 7'($random(seed));
    settle;
    check8({7'h0, source_pending_bits[15]}, 8'h01, "pending");
    check8({1'b0, source_pending_bits[14:8]}, 8'h00, "unwired pending");
    rd(12'h718, 8'h08);
    ack(3'h3, vec(15), 8'h34);
    rd(12'h7EC, vec(15));
    periph_req[15] = 1'b0;
    settle;
    ack(3'h3, vec(3), 8'h38);
    edge_flag_register[3] = 1'b0;
    settle;
    ack(3'h3, vec(16), 8'h33);
    periph_req[40] = 1'b1;
    settle;
    rd(12'h718, 8'h28);
    sw(vec(40), {4'h5, 1'b0, r});
    rd(12'hFE0, vec(40));
    source_mask_bits[40] = 1'b1;
    settle;
    check8({7'h0, source_pending_bits[40]}, 8'h01, "masked pending");
    rd(12'h718, 8'h08);
    sw(vec(16), 8'h33);
    software_force_bits[40] = 1'b1;
    settle;
    sw(vec(40), {4'h5, 1'b0, r});
    software_force_bits[40] = 1'b0;
    source_mask_bits[40] = 1'b0;
    periph_req[40] = 1'b0;
    usb_req = 9'($random(seed)) | 9'h101;
    settle;
    sw(vec(24), 8'h70);
    ack(3'h0, vec(24), 8'h70);
    ack(3'h6, 8'h00, 8'h00);
    usb_req[7:0] = 8'h00;
    settle;
    rd(12'h718, 8'h88);
    usb_req = '0;
    periph_req = '0;
    settle;
    rd(12'h718, 8'h00);
    sw(8'h00, 8'h00);
    rd(12'h700, 8'h00);
    core.wr(12'h719, 8'hFF);
    rd(12'h719, 8'h00);
    settle;
    // Reset in mid-run must clear the programmed control bytes
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    rd(12'h74F, 8'h00);
    // Let the monitor take the last answer before the verdict
    settle;
    finish_test;
  end
endmodule
